// [design/sidl_pkg.sv]
// shared constants of the id page link: command codes, address fields,
// write timing and the controller's register map.
// assumes a 20 MHz system clock on both ends.
package sidl_pkg;
  localparam int         PAGE_BYTES        = 32;
  localparam logic [7:0] CMD_WRITE_ENABLE  = 8'h06;
  localparam logic [7:0] CMD_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] CMD_ID_WRITE      = 8'h82;
  localparam logic [7:0] CMD_ID_READ       = 8'h83;
  localparam int         ID_SPACE_SEL_BIT  = 10;
  localparam int         LOCK_DATA_BIT     = 1;
  localparam logic [7:0] ERASED_BYTE       = 8'hFF;
  localparam logic [1:0] BP_ALL            = 2'h3;
  localparam int         CLK_HZ            = 20_000_000;
  localparam int         TW_US             = 1000;
  localparam int         TW_CYC            = TW_US * (CLK_HZ / 1_000_000);
  localparam logic [7:0] REG_CTRL          = 8'h00;
  localparam logic [7:0] REG_TXD           = 8'h04;
  localparam logic [7:0] REG_RXD           = 8'h08;
  localparam logic [7:0] REG_STAT          = 8'h0C;
  localparam logic [7:0] REG_DIV           = 8'h10;
  localparam int         CTRL_GO_BIT       = 0;
  localparam int         CTRL_CS_BIT       = 1;
  localparam logic [7:0] DIV_RST           = 8'h04;
endpackage : sidl_pkg

// [design/sidl_if.sv]
// serial link between the id page device and its host controller.
// assumes the bench joins both modports; all four wires are plain levels.
`timescale 1ns/1ns
`default_nettype none
interface sidl_if;
  logic cs_n;
  logic sck;
  logic mosi;
  logic miso;
  modport dev  (input cs_n, input sck, input mosi, output miso);
  modport host (output cs_n, output sck, output mosi, input miso);
endinterface : sidl_if
`default_nettype wire

// [design/sidl_sync.sv]
// three-stage input synchroniser with filtered level and edge pulses.
// assumes d is asynchronous to clk.
`timescale 1ns/1ns
`default_nettype none
module sidl_sync #(
  parameter logic INIT = 1'b0
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic d,
  output logic      q,
  output logic      rise,
  output logic      fall
);
  logic s1;
  logic s2;
  logic s3;

  // s1 feeds s2 only; a change counts once s2 and s3 agree
  always_ff @(posedge clk) begin
    if (rst) begin
      s1 <= INIT;
      s2 <= INIT;
      s3 <= INIT;
      q  <= INIT;
    end else begin
      s1 <= d;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) begin
        q <= s3;
      end
    end
  end

  assign rise = (s2 == s3) && s3 && !q;
  assign fall = (s2 == s3) && !s3 && q;
endmodule : sidl_sync
`default_nettype wire

// [design/sidl_dev.sv]
// device end: id page write, lock status read and page lock.
// assumes CLK much faster than the link clock (at least 8 CLK per link period);
// nonvolatile state survives RST and is set to delivery state by NV_ERASE.
// Notes on behaviour
// - one lockable 32-byte identification page
// - host: cs low, command, address, data
// - id select low for write; low five bits index
// - host: lock read sends id select high
// - lock status byte lsb shows lock
// - status byte repeats until cs rises
// - lock needs write enable first
// - lock data byte must have bit one set
// - cs must rise right after eighth bit (code takes a rise after any whole data byte, lock bit from the last)
// - good lock frame starts timed write
// - lock ignored during write cycle
// - lock ignored when both protect bits set
// - lock ignored on cs rise off boundary
// - cs falling edge needed after power-up (code counts cs already low at reset release as one)
// - power-up clears enable latch and busy
// - protect and disable bits survive power loss
// - delivered protect and disable bits zero
// - write cycle end clears busy flag
//
// Decided for this implementation: the register offsets and the Wishbone register port.
`timescale 1ns/1ns
`default_nettype none
module sidl_dev #(
  parameter int WRITE_CYCLES = sidl_pkg::TW_CYC,
  parameter int PAGE_BYTES   = sidl_pkg::PAGE_BYTES
) (
  input  wire logic       CLK,
  input  wire logic       RST,
  sidl_if.dev             LINK,
  input  wire logic       NV_ERASE,
  input  wire logic       NV_STATUS_WE,
  input  wire logic [2:0] NV_STATUS_IN,
  output logic            WRITE_ENABLE_LATCH,
  output logic            WRITE_IN_PROGRESS_FLAG,
  output logic            ID_LOCKED,
  output logic            STATUS_WRITE_DISABLE_BIT,
  output logic            BLOCK_PROTECT_HIGH,
  output logic            BLOCK_PROTECT_LOW
);
  localparam int AW   = $clog2(PAGE_BYTES);
  localparam int TW_W = $clog2(WRITE_CYCLES + 1);
  localparam int SEL  = sidl_pkg::ID_SPACE_SEL_BIT - 8;

  typedef enum logic [2:0] {ST_WAIT, ST_CMD, ST_ADDR, ST_DIN, ST_DOUT, ST_SKIP} sidl_dst_t;

  sidl_dst_t             state;
  sidl_dst_t             next_state;
  logic                  sck_rise;
  logic                  sck_fall;
  logic                  cs_rise;
  logic                  cs_fall;
  logic                  mosi_q;
  logic [2:0]            bit_cnt;
  logic [7:0]            sh;
  logic [7:0]            cmd;
  logic [7:0]            addr_hi;
  logic [7:0]            out_byte;
  logic                  addr_cnt;
  logic                  id_op;
  logic                  got_byte;
  logic                  lock_bit;
  logic                  pend_lock;
  logic                  miso;
  logic [AW-1:0]         ptr;
  logic                  write_enable_latch;
  logic                  write_in_progress_flag;
  logic [TW_W-1:0]       tw_cnt;
  logic                  locked;
  logic                  status_write_disable_bit;
  logic [1:0]            bp;
  logic [7:0]            page [PAGE_BYTES];
  logic [7:0]            wbuf [PAGE_BYTES];
  logic [PAGE_BYTES-1:0] mask;

  sidl_sync #(.INIT(1'b0)) u_sck (
    .clk  (CLK),
    .rst  (RST),
    .d    (LINK.sck),
    .q    (),
    .rise (sck_rise),
    .fall (sck_fall)
  );
  // cs starts high so a high level at release is no edge; a low level there counts as a falling edge
  sidl_sync #(.INIT(1'b1)) u_cs (
    .clk  (CLK),
    .rst  (RST),
    .d    (LINK.cs_n),
    .q    (),
    .rise (cs_rise),
    .fall (cs_fall)
  );
  sidl_sync #(.INIT(1'b0)) u_mosi (
    .clk  (CLK),
    .rst  (RST),
    .d    (LINK.mosi),
    .q    (mosi_q),
    .rise (),
    .fall ()
  );

  wire [7:0]    byte_in   = {sh[6:0], mosi_q};
  wire          byte_end  = sck_rise && (bit_cnt == 3'h7) && (state != ST_WAIT);
  wire [AW-1:0] ptr_nx    = ptr + 1'b1;
  wire [AW-1:0] ptr_addr  = byte_in[AW-1:0];
  wire [7:0]    lock_byte = {7'h00, locked};
  wire          frame_ok  = cs_rise && (state == ST_DIN) && (bit_cnt == 3'h0) && got_byte;
  wire          lock_go   = frame_ok && id_op && lock_bit && write_enable_latch && !write_in_progress_flag && (bp != sidl_pkg::BP_ALL);
  wire          idw_go    = frame_ok && !id_op && write_enable_latch && !write_in_progress_flag && !locked;
  wire          start     = lock_go || idw_go;
  wire          cmd_ok    = cs_rise && (state == ST_SKIP) && (bit_cnt == 3'h0) && !write_in_progress_flag;
  wire          write_enable_command_go   = cmd_ok && (cmd == sidl_pkg::CMD_WRITE_ENABLE);
  wire          wrdi_go   = cmd_ok && (cmd == sidl_pkg::CMD_WRITE_DISABLE);
  wire          wip_done  = write_in_progress_flag && (tw_cnt == TW_W'(WRITE_CYCLES - 1));

  always_comb begin
    next_state = state;
    unique case (state)
      ST_WAIT: next_state = ST_WAIT;
      ST_CMD: begin
        // id commands refused while a write cycle runs
        if (!write_in_progress_flag && (byte_in == sidl_pkg::CMD_ID_WRITE || byte_in == sidl_pkg::CMD_ID_READ)) begin
          next_state = ST_ADDR;
        end else begin
          next_state = ST_SKIP;
        end
      end
      ST_ADDR: begin
        if (addr_cnt) begin
          next_state = (cmd == sidl_pkg::CMD_ID_READ) ? ST_DOUT : ST_DIN;
        end
      end
      ST_DIN, ST_DOUT, ST_SKIP: next_state = state;
      default: next_state = ST_WAIT;
    endcase
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      state <= ST_WAIT;
    end else if (cs_fall) begin
      state <= ST_CMD;
    end else if (cs_rise) begin
      state <= ST_WAIT;
    end else if (byte_end) begin
      state <= next_state;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST || cs_fall) begin
      bit_cnt  <= 3'h0;
      addr_cnt <= 1'b0;
      got_byte <= 1'b0;
    end else if (sck_rise && state != ST_WAIT) begin
      bit_cnt  <= bit_cnt + 3'h1;
      sh       <= byte_in;
      got_byte <= got_byte || (byte_end && state == ST_DIN);
      if (byte_end && state == ST_ADDR) begin
        addr_cnt <= 1'b1;
      end
    end
  end

  // staging buffer keeps a refused or broken frame from touching the page
  always_ff @(posedge CLK) begin
    if (RST) begin
      mask <= '0;
    end else if (cs_fall && !write_in_progress_flag) begin
      mask <= '0;
    end else if (byte_end) begin
      unique case (state)
        ST_CMD: cmd <= byte_in;
        ST_ADDR: begin
          addr_hi <= byte_in;
          if (addr_cnt) begin
            ptr      <= ptr_addr;
            id_op    <= addr_hi[SEL];
            out_byte <= addr_hi[SEL] ? lock_byte : page[ptr_addr];
          end
        end
        ST_DIN: begin
          if (id_op) begin
            lock_bit <= byte_in[sidl_pkg::LOCK_DATA_BIT];
          end else begin
            wbuf[ptr]  <= byte_in;
            mask[ptr]  <= 1'b1;
            ptr        <= ptr_nx;
          end
        end
        ST_DOUT: begin
          // status byte stays put; page read advances
          if (!id_op) begin
            ptr      <= ptr_nx;
            out_byte <= page[ptr_nx];
          end
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      write_enable_latch       <= 1'b0;
      write_in_progress_flag       <= 1'b0;
      tw_cnt    <= '0;
      pend_lock <= 1'b0;
    end else if (write_in_progress_flag) begin
      tw_cnt <= tw_cnt + 1'b1;
      if (wip_done) begin
        write_in_progress_flag <= 1'b0;
        write_enable_latch <= 1'b0;
      end
    end else if (start) begin
      write_in_progress_flag       <= 1'b1;
      tw_cnt    <= '0;
      pend_lock <= lock_go;
    end else if (write_enable_command_go) begin
      write_enable_latch <= 1'b1;
    end else if (wrdi_go) begin
      write_enable_latch <= 1'b0;
    end
  end

  // nonvolatile cells: RST models power-up and leaves them alone
  always_ff @(posedge CLK) begin
    if (NV_ERASE) begin
      locked <= 1'b0;
      status_write_disable_bit   <= 1'b0;
      bp     <= 2'h0;
      for (int i = 0; i < PAGE_BYTES; i++) begin
        page[i] <= sidl_pkg::ERASED_BYTE;
      end
    end else begin
      if (NV_STATUS_WE) begin
        {status_write_disable_bit, bp} <= NV_STATUS_IN;
      end
      if (wip_done && pend_lock) begin
        locked <= 1'b1;
      end
      for (int i = 0; i < PAGE_BYTES; i++) begin
        if (wip_done && !pend_lock && mask[i]) begin
          page[i] <= wbuf[i];
        end
      end
    end
  end

  // mode 0: next bit goes out on each falling link clock
  always_ff @(posedge CLK) begin
    if (RST || state != ST_DOUT) begin
      miso <= 1'b0;
    end else if (sck_fall) begin
      miso <= out_byte[~bit_cnt];
    end
  end

  assign LINK.miso                = miso;
  assign WRITE_ENABLE_LATCH       = write_enable_latch;
  assign WRITE_IN_PROGRESS_FLAG   = write_in_progress_flag;
  assign ID_LOCKED                = locked;
  assign STATUS_WRITE_DISABLE_BIT = status_write_disable_bit;
  assign BLOCK_PROTECT_HIGH       = bp[1];
  assign BLOCK_PROTECT_LOW        = bp[0];
endmodule : sidl_dev
`default_nettype wire

// [design/sidl_host.sv]
// host end: byte-wise serial controller driven from classic wishbone registers.
// assumes software sequences frames; chip select changes only between bytes.
`timescale 1ns/1ns
`default_nettype none
module sidl_host (
  input  wire logic        CLK,
  input  wire logic        RST,
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_WE_I,
  input  wire logic [7:0]  WB_ADR_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic [31:0] WB_DAT_I,
  output logic      [31:0] WB_DAT_O,
  output logic             WB_ACK_O,
  sidl_if.host             LINK
);
  // miso comes back eight cycles after a link clock fall (both synchronisers),
  // so each bit is taken a fixed four cycles after the following fall
  localparam logic [7:0] MISO_LAG = 8'h03;

  typedef enum logic [1:0] {HS_IDLE, HS_LOW, HS_HIGH, HS_TAIL} sidl_hst_t;

  sidl_hst_t  hs;
  logic       ack;
  logic [31:0] dat_o;
  logic       cs_on;
  logic [7:0] tx;
  logic [7:0] rx;
  logic [7:0] sh;
  logic [7:0] div;
  logic [7:0] cnt;
  logic [2:0] bits;
  logic       sck;
  logic       miso_q;

  sidl_sync #(.INIT(1'b0)) u_miso (
    .clk  (CLK),
    .rst  (RST),
    .d    (LINK.miso),
    .q    (miso_q),
    .rise (),
    .fall ()
  );

  wire        req     = WB_CYC_I && WB_STB_I;
  wire        wr      = req && ack && WB_WE_I && WB_SEL_I[0];
  wire        busy    = (hs != HS_IDLE);
  wire        ctrl_wr = wr && (WB_ADR_I == sidl_pkg::REG_CTRL) && !busy;
  wire        go      = ctrl_wr && WB_DAT_I[sidl_pkg::CTRL_GO_BIT];
  wire        half    = (cnt == div - 8'h01);
  wire [31:0] rd_data =
    (WB_ADR_I == sidl_pkg::REG_CTRL) ? 32'({cs_on, 1'b0}) :
    (WB_ADR_I == sidl_pkg::REG_TXD)  ? 32'(tx) :
    (WB_ADR_I == sidl_pkg::REG_RXD)  ? 32'(rx) :
    (WB_ADR_I == sidl_pkg::REG_STAT) ? 32'(busy) :
    (WB_ADR_I == sidl_pkg::REG_DIV)  ? 32'(div) : 32'h0000_0000;

  // ack one cycle after the request; writes land on the ack edge
  always_ff @(posedge CLK) begin
    if (RST) begin
      ack   <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else begin
      ack <= req && !ack;
      if (req && !ack) begin
        dat_o <= rd_data;
      end
    end
  end

  // cs held while a byte shifts so it only rises on a boundary
  always_ff @(posedge CLK) begin
    if (RST) begin
      cs_on <= 1'b0;
      tx    <= 8'h00;
      div   <= sidl_pkg::DIV_RST;
    end else begin
      if (ctrl_wr) begin
        cs_on <= WB_DAT_I[sidl_pkg::CTRL_CS_BIT];
      end
      if (wr && WB_ADR_I == sidl_pkg::REG_TXD) begin
        tx <= WB_DAT_I[7:0];
      end
      if (wr && WB_ADR_I == sidl_pkg::REG_DIV) begin
        div <= WB_DAT_I[7:0];
      end
    end
  end

  // bit n is taken after fall n+1; the tail state waits out the last bit
  always_ff @(posedge CLK) begin
    if (RST) begin
      hs   <= HS_IDLE;
      sck  <= 1'b0;
      cnt  <= 8'h00;
      bits <= 3'h0;
      sh   <= 8'h00;
      rx   <= 8'h00;
    end else begin
      unique case (hs)
        HS_IDLE: begin
          if (go) begin
            hs   <= HS_LOW;
            cnt  <= 8'h00;
            bits <= 3'h0;
            sh   <= tx;
          end
        end
        HS_LOW: begin
          cnt <= half ? 8'h00 : cnt + 8'h01;
          if ((bits != 3'h0) && (cnt == MISO_LAG)) begin
            rx <= {rx[6:0], miso_q};
          end
          if (half) begin
            sck <= 1'b1;
            hs  <= HS_HIGH;
          end
        end
        HS_HIGH: begin
          cnt <= half ? 8'h00 : cnt + 8'h01;
          if (half) begin
            sck  <= 1'b0;
            sh   <= {sh[6:0], 1'b0};
            bits <= bits + 3'h1;
            hs   <= (bits == 3'h7) ? HS_TAIL : HS_LOW;
          end
        end
        HS_TAIL: begin
          cnt <= cnt + 8'h01;
          if (cnt == MISO_LAG) begin
            rx <= {rx[6:0], miso_q};
            hs <= HS_IDLE;
          end
        end
      endcase
    end
  end

  assign WB_DAT_O  = dat_o;
  assign WB_ACK_O  = ack;
  assign LINK.cs_n = ~cs_on;
  assign LINK.sck  = sck;
  assign LINK.mosi = sh[7];
endmodule : sidl_host
`default_nettype wire

// [test/sidl_assertions.sv]
// checker for the id page link: watches the wires and the device's status outputs.
// assumes one clock domain and a synchronous active high reset.
`timescale 1ns/1ns
`default_nettype none
module sidl_assertions #(
  parameter int WRITE_CYCLES = sidl_pkg::TW_CYC
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic mosi,
  input wire logic miso,
  input wire logic WRITE_ENABLE_LATCH,
  input wire logic WRITE_IN_PROGRESS_FLAG,
  input wire logic ID_LOCKED,
  input wire logic BLOCK_PROTECT_HIGH,
  input wire logic BLOCK_PROTECT_LOW
);
  localparam int CYC_MIN = WRITE_CYCLES - 2;
  localparam int CYC_MAX = WRITE_CYCLES + 2;
  logic [15:0] busy_cnt;
  wire         write_in_progress_flag = WRITE_IN_PROGRESS_FLAG;

  // counts busy cycles; a plain repetition would be far too long to unroll
  always_ff @(posedge CLK) begin
    if (RST || !write_in_progress_flag) busy_cnt <= 16'h0000;
    else busy_cnt <= busy_cnt + 16'h0001;
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  a_miso_quiet: assert property (cs_n && $past(cs_n, 8) |-> !miso)
    else $error("data out active while deselected");
  a_wip_len: assert property ($fell(write_in_progress_flag) |-> busy_cnt >= CYC_MIN && busy_cnt <= CYC_MAX)
    else $error("write cycle length off");
  a_wip_needs_wel: assert property ($rose(write_in_progress_flag) |-> WRITE_ENABLE_LATCH)
    else $error("write cycle without enable latch");
  a_wip_after_cs: assert property ($rose(write_in_progress_flag) |-> cs_n && $past(cs_n, 2))
    else $error("write cycle not started by deselect");
  a_wel_clears: assert property ($fell(write_in_progress_flag) |-> ##[0:2] !WRITE_ENABLE_LATCH)
    else $error("enable latch kept after write cycle");
  a_lock_at_end: assert property ($rose(ID_LOCKED) |-> $past(write_in_progress_flag) || $past(write_in_progress_flag, 2))
    else $error("lock set outside a write cycle");
  a_lock_bp_block: assert property ($rose(ID_LOCKED) |-> !(BLOCK_PROTECT_HIGH && BLOCK_PROTECT_LOW))
    else $error("lock set with full protection");
  a_reset_clear: assert property ($fell(RST) |-> !WRITE_ENABLE_LATCH && !write_in_progress_flag)
    else $error("latch or busy set after reset");
  a_no_wel_busy: assert property (write_in_progress_flag && $past(write_in_progress_flag) |-> !$rose(WRITE_ENABLE_LATCH))
    else $error("enable latch set during write cycle");

  c_write_cycle: cover property ($rose(write_in_progress_flag));
  c_locked: cover property ($rose(ID_LOCKED));
  c_frame: cover property ($fell(cs_n) ##[1:200] $rose(sck));
  c_data_one: cover property (!cs_n && $rose(sck) && mosi);
endmodule : sidl_assertions
`default_nettype wire

// [test/sidl_test.sv]
// self-checking bench: host end driven over classic wishbone, device end beside it.
// assumes the design files and the checker are compiled first.
`timescale 1ns/1ns
`default_nettype none
module sidl_test;
  localparam int         WCYC = 600;
  localparam logic [7:0] WRC  = sidl_pkg::CMD_ID_WRITE;
  localparam logic [7:0] RDC  = sidl_pkg::CMD_ID_READ;
  localparam logic [7:0] WEN  = sidl_pkg::CMD_WRITE_ENABLE;
  localparam logic [7:0] WDI  = sidl_pkg::CMD_WRITE_DISABLE;
  localparam logic [7:0] FF   = sidl_pkg::ERASED_BYTE;
  logic        clk = 1'b0, rst = 1'b1;
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [3:0]  sel = 4'h0;
  logic [31:0] dat = 32'h0000_0000;
  logic [31:0] dat_o;
  logic        ack, nv_erase = 1'b0, nv_we = 1'b0;
  logic [2:0]  nv_in = 3'h0;
  logic        write_enable_latch, write_in_progress_flag, locked, status_write_disable_bit, bph, bpl;
  int          fail_count = 0, checks = 0;
  logic [7:0]  rxq[$];

  sidl_if link();
  sidl_dev #(.WRITE_CYCLES(WCYC)) u_sidl_dev (.CLK(clk), .RST(rst), .LINK(link),
    .NV_ERASE(nv_erase), .NV_STATUS_WE(nv_we), .NV_STATUS_IN(nv_in),
    .WRITE_ENABLE_LATCH(write_enable_latch), .WRITE_IN_PROGRESS_FLAG(write_in_progress_flag), .ID_LOCKED(locked),
    .STATUS_WRITE_DISABLE_BIT(status_write_disable_bit), .BLOCK_PROTECT_HIGH(bph), .BLOCK_PROTECT_LOW(bpl));
  sidl_host u_sidl_host (.CLK(clk), .RST(rst), .WB_CYC_I(cyc), .WB_STB_I(stb),
    .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat), .WB_DAT_O(dat_o),
    .WB_ACK_O(ack), .LINK(link));
  sidl_assertions #(.WRITE_CYCLES(WCYC)) u_sidl_assertions (.CLK(clk), .RST(rst),
    .cs_n(link.cs_n), .sck(link.sck), .mosi(link.mosi), .miso(link.miso),
    .WRITE_ENABLE_LATCH(write_enable_latch), .WRITE_IN_PROGRESS_FLAG(write_in_progress_flag), .ID_LOCKED(locked),
    .BLOCK_PROTECT_HIGH(bph), .BLOCK_PROTECT_LOW(bpl));

  always #25 clk = ~clk;

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : chk

  // one classic cycle; waits for ack with no cycle count assumed
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d,
                    output logic [7:0] r);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    sel <= 4'h1;
    dat <= {24'h00_0000, d};
    @(posedge clk);
    while (ack !== 1'b1) @(posedge clk);
    r = dat_o[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
  endtask : wb

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] r;
    wb(1'b1, a, d, r);
  endtask : wr

  task automatic xfer(input logic [7:0] b);
    logic [7:0] r;
    wr(sidl_pkg::REG_TXD, b);
    wr(sidl_pkg::REG_CTRL, 8'h03);
    r = 8'h01;
    while (r[0] !== 1'b0) wb(1'b0, sidl_pkg::REG_STAT, 8'h00, r);
    wb(1'b0, sidl_pkg::REG_RXD, 8'h00, r);
    rxq.push_back(r);
  endtask : xfer

  // deselect only between bytes, so every frame ends on a byte boundary
  task automatic frame(input logic [7:0] tx[$]);
    rxq = {};
    wr(sidl_pkg::REG_CTRL, 8'h02);
    foreach (tx[i]) xfer(tx[i]);
    wr(sidl_pkg::REG_CTRL, 8'h00);
    // room for the device's three-flop synchroniser to see the deselect
    repeat (8) @(posedge clk);
  endtask : frame

  task automatic settle;
    while (write_in_progress_flag !== 1'b0) @(posedge clk);
  endtask : settle

  task automatic nv(input logic e, input logic [2:0] v);
    @(posedge clk);
    nv_erase <= e;
    nv_we    <= !e;
    nv_in    <= v;
    @(posedge clk);
    nv_erase <= 1'b0;
    nv_we    <= 1'b0;
  endtask : nv

  task automatic t_delivery;
    nv(1'b1, 3'h0);
    @(posedge clk);
    chk("status bits", 8'h00, {5'h00, status_write_disable_bit, bph, bpl});
    frame('{RDC, 8'h00, 8'h1F, 8'h00, 8'h00});
    chk("page byte 31", FF, rxq[3]);
    chk("page byte 0", FF, rxq[4]);
    frame('{RDC, 8'h04, 8'h00, 8'h00, 8'h00, 8'h00});
    chk("lock status", 8'h00, rxq[3]);
    chk("lock repeat", 8'h00, rxq[5]);
  endtask : t_delivery

  task automatic t_write_wrap;
    frame('{WRC, 8'h00, 8'h03, 8'h5A});
    chk("busy no latch", 8'h00, {7'h00, write_in_progress_flag});
    frame('{WEN});
    chk("latch set", 8'h01, {7'h00, write_enable_latch});
    frame('{WRC, 8'h03, 8'hFF, 8'h11, 8'h22});
    chk("write busy", 8'h01, {7'h00, write_in_progress_flag});
    settle();
    chk("latch after write", 8'h00, {7'h00, write_enable_latch});
    frame('{RDC, 8'h00, 8'h1F, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00});
    chk("byte 31", 8'h11, rxq[3]);
    chk("wrapped byte 0", 8'h22, rxq[4]);
    chk("unwritten byte 3", FF, rxq[7]);
  endtask : t_write_wrap

  task automatic t_lock_refused;
    frame('{WEN});
    frame('{WDI});
    chk("latch after disable", 8'h00, {7'h00, write_enable_latch});
    frame('{WRC, 8'h04, 8'h00, 8'h02});
    chk("lock no latch", 8'h00, {6'h00, write_in_progress_flag, locked});
    nv(1'b0, 3'h3);
    frame('{WEN});
    frame('{WRC, 8'h04, 8'h00, 8'h02});
    chk("lock protected", 8'h00, {6'h00, write_in_progress_flag, locked});
    nv(1'b0, 3'h0);
    frame('{WRC, 8'h04, 8'h00});
    chk("lock no data", 8'h00, {6'h00, write_in_progress_flag, locked});
    frame('{WRC, 8'h00, 8'h00, 8'h44});
    frame('{WRC, 8'h04, 8'h00, 8'h02});
    chk("still busy", 8'h01, {7'h00, write_in_progress_flag});
    settle();
    chk("lock while busy", 8'h00, {7'h00, locked});
  endtask : t_lock_refused

  task automatic t_lock_good;
    frame('{WEN});
    frame('{WRC, 8'hFC, 8'h1F, 8'hFE});
    chk("lock busy", 8'h01, {7'h00, write_in_progress_flag});
    settle();
    chk("locked, latch", 8'h02, {6'h00, locked, write_enable_latch});
    frame('{RDC, 8'h04, 8'h00, 8'h00, 8'h00});
    chk("lock status", 8'h01, rxq[3]);
    chk("lock repeat", 8'h01, rxq[4]);
    frame('{WEN});
    frame('{WRC, 8'h00, 8'h05, 8'h00});
    chk("write when locked", 8'h00, {7'h00, write_in_progress_flag});
    frame('{RDC, 8'h00, 8'h05, 8'h00});
    chk("locked byte 5", FF, rxq[3]);
  endtask : t_lock_good

  task automatic t_power_cycle;
    nv(1'b0, 3'h5);
    @(posedge clk);
    rst <= 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    chk("latch, busy", 8'h00, {6'h00, write_enable_latch, write_in_progress_flag});
    chk("kept bits", 8'h0D, {4'h0, locked, status_write_disable_bit, bph, bpl});
    frame('{RDC, 8'h07, 8'hAA, 8'h00});
    chk("status after reset", 8'h01, rxq[3]);
  endtask : t_power_cycle

  task automatic complete_run;
    $display("checks %0d, mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : complete_run

  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_delivery();
    t_write_wrap();
    t_lock_refused();
    t_lock_good();
    t_power_cycle();
    complete_run();
  end

  // about eight thousand cycles are needed; five times that means a hang
  initial begin
    repeat (40000) @(posedge clk);
    fail_count++;
    complete_run();
  end
endmodule : sidl_test
`default_nettype wire
